/* File: aux_sensor_packet_codec.sv */
// Purpose: Payload codec for external aiding, time, field, geoid and correction packets
// Assumes: Header and checksum are handled upstream; all ports on REF_CLK_I
// Notes:   Writable payloads other than packet 55 land in a spare bank, swapped in only when complete
`timescale 1ns/1ps
// Notes on behaviour
// - Packet 46 is a 24-byte read/write payload of six floats: N, E, D velocity then their deviations.
// - Packet 47 is accepted with 16 bytes (one shared deviation) or 24 bytes (one per axis).
// - Packet 47 has X, Y, Z velocity at 0, 4, 8, X deviation at 12, optional Y, Z deviations at 16, 20.
// - Packet 48 is an 8-byte read/write payload: heading at 0 and its deviation at 4, in radians.
// - Packet 49 is read-only, 8 bytes: whole seconds since power-on, then microseconds.
// - Packet 50 is read-only, 12 bytes: local magnetic field X, Y, Z in milligauss.
// - Packet 52 is read-only, 8 bytes: Unix seconds then microseconds.
// - Packet 54 is read-only, 4 bytes: one float of geoid height in metres.
// - Packet 55 is write-only, up to 255 bytes, forwarded unaltered to the satellite receiver.
module aux_sensor_packet_codec
  import codec_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  // Incoming payload stream
  input wire logic RX_START_I,
  input wire logic [7:0] RX_ID_I,
  input wire logic [7:0] RX_LEN_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_LAST_I,
  output logic RX_READY_O,
  output logic RX_ERR_O,
  // Aiding update to the navigation core
  output logic UPD_O,
  output logic [7:0] UPD_ID_O,
  input wire logic [1:0] NAV_SLOT_I,
  input wire logic [4:0] NAV_IDX_I,
  output logic [7:0] NAV_DATA_O,
  output logic NAV_BODY_LONG_O,
  // Live values from the navigation core
  input wire logic [31:0] MAG_X_I,
  input wire logic [31:0] MAG_Y_I,
  input wire logic [31:0] MAG_Z_I,
  input wire logic [31:0] UNIX_SEC_I,
  input wire logic [31:0] UNIX_USEC_I,
  input wire logic [31:0] GEOID_I,
  // Correction bytes to the satellite receiver
  output logic RTCM_VALID_O,
  output logic [7:0] RTCM_DATA_O,
  input wire logic RTCM_READY_I,
  // Outgoing payload stream
  input wire logic TX_REQ_I,
  input wire logic [7:0] TX_ID_I,
  output logic TX_START_O,
  output logic [7:0] TX_LEN_O,
  output logic TX_ERR_O,
  output logic TX_VALID_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_LAST_O,
  input wire logic TX_READY_I
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Store slot of a writable packet
  function automatic logic [1:0] slot_of(input logic [7:0] id);
    case (id)
      ID_EXT_VEL: slot_of = SLOT_EXT_VEL;
      ID_BODY_VEL: slot_of = SLOT_BODY_VEL;
      ID_EXT_HDG: slot_of = SLOT_EXT_HDG;
      default: slot_of = SLOT_NONE;
    endcase
  endfunction : slot_of

  // Allowed incoming length
  function automatic logic len_ok(input logic [7:0] id, input logic [7:0] len);
    case (id)
      ID_EXT_VEL: len_ok = (len == LEN_EXT_VEL);
      ID_BODY_VEL: len_ok = (len == LEN_BODY_SHORT) || (len == LEN_BODY_LONG);
      ID_EXT_HDG: len_ok = (len == LEN_EXT_HDG);
      ID_RTCM: len_ok = (len >= LEN_RTCM_MIN) && (len <= LEN_RTCM_MAX);
      default: len_ok = 1'b0;
    endcase
  endfunction : len_ok

  // Outgoing length, zero when not readable
  function automatic logic [7:0] rd_len(input logic [7:0] id, input logic body_long);
    case (id)
      ID_EXT_VEL: rd_len = LEN_EXT_VEL;
      ID_BODY_VEL: rd_len = body_long ? LEN_BODY_LONG : LEN_BODY_SHORT;
      ID_EXT_HDG: rd_len = LEN_EXT_HDG;
      ID_RUN_TIME: rd_len = LEN_RUN_TIME;
      ID_MAG_FIELD: rd_len = LEN_MAG_FIELD;
      ID_EXT_TIME: rd_len = LEN_EXT_TIME;
      ID_GEOID: rd_len = LEN_GEOID;
      default: rd_len = LEN_NONE;
    endcase
  endfunction : rd_len

  ////////////////////////////////////////////////////////////////////////////
  // Store and bank state

  store_if st ();
  pay_store u_store (.clk_i(REF_CLK_I), .st(st));

  logic [2:0] act_q;      // Active bank per slot
  logic [1:0] long_q;     // Per-axis deviation form, per bank of packet 47
  logic act_sel;
  assign act_sel = act_q[NAV_SLOT_I == SLOT_NONE ? SLOT_EXT_VEL : NAV_SLOT_I];
  assign st.raddr_b = {act_sel, NAV_SLOT_I, NAV_IDX_I};
  assign NAV_DATA_O = st.rdata_b;
  assign NAV_BODY_LONG_O = long_q[act_q[SLOT_BODY_VEL]];

  ////////////////////////////////////////////////////////////////////////////
  // Receive path

  rx_state_t rx_state_q;
  logic [7:0] rx_id_q;
  logic [7:0] rx_len_q;
  logic [7:0] rx_cnt_q;
  logic rx_over_q;
  logic [1:0] rx_slot;
  logic rx_take;
  logic rx_fit;
  logic commit;
  logic rtcm_valid_q;
  logic [7:0] rtcm_data_q;

  assign rx_slot = slot_of(rx_id_q);
  // Correction bytes stall the link while the receiver is busy
  assign RX_READY_O = (rx_state_q != R_TAKE) || (rx_id_q != ID_RTCM) || !rtcm_valid_q
                      || RTCM_READY_I;
  assign rx_take = RX_VALID_I && RX_READY_O && (rx_state_q != R_IDLE);
  assign rx_fit = (rx_cnt_q == 8'(rx_len_q - 8'h01)) && !rx_over_q;
  assign commit = (rx_state_q == R_TAKE) && rx_take && RX_LAST_I && rx_fit;

  // Receive sequencing; bad lengths drain to the end untouched
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      rx_state_q <= R_IDLE;
    end
    else
    begin
      case (rx_state_q)
        R_IDLE:
          // length screen
          // A zero-length header has no bytes to drain, so it stays idle
          if (RX_START_I && RX_LEN_I == LEN_NONE)
          begin
            rx_state_q <= R_IDLE;
          end
          else if (RX_START_I)
          begin
            rx_state_q <= len_ok(RX_ID_I, RX_LEN_I) ? R_TAKE : R_DROP;
          end
        R_TAKE, R_DROP:
          if (rx_take && RX_LAST_I)
          begin
            rx_state_q <= R_IDLE;
          end
        default: rx_state_q <= R_IDLE;
      endcase
    end
  end

  // Header capture and byte count
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      rx_id_q <= 8'h00;
      rx_len_q <= 8'h00;
      rx_cnt_q <= 8'h00;
      rx_over_q <= 1'b0;
    end
    else if (rx_state_q == R_IDLE && RX_START_I)
    begin
      rx_id_q <= RX_ID_I;
      rx_len_q <= RX_LEN_I;
      rx_cnt_q <= 8'h00;
      rx_over_q <= 1'b0;
    end
    else if (rx_take)
    begin
      rx_cnt_q <= 8'(rx_cnt_q + 8'h01);
      rx_over_q <= rx_over_q || (rx_cnt_q == 8'hff);
    end
  end

  // bytes stored in arrival order, so field offsets hold as sent
  assign st.we = (rx_state_q == R_TAKE) && rx_take && (rx_slot != SLOT_NONE)
                 && (rx_cnt_q < rx_len_q);
  assign st.waddr = {~act_q[rx_slot == SLOT_NONE ? SLOT_EXT_VEL : rx_slot], rx_slot,
                     rx_cnt_q[IDX_W-1:0]};
  assign st.wdata = RX_DATA_I;

  // bank swap on a complete payload
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      act_q <= 3'h0;
      long_q <= 2'h0;
    end
    else if (commit && rx_slot != SLOT_NONE)
    begin
      act_q[rx_slot] <= ~act_q[rx_slot];
      if (rx_slot == SLOT_BODY_VEL)
      begin
        long_q[~act_q[SLOT_BODY_VEL]] <= (rx_len_q == LEN_BODY_LONG);
      end
    end
  end

  // Update and error pulses
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      UPD_O <= 1'b0;
      UPD_ID_O <= 8'h00;
      RX_ERR_O <= 1'b0;
    end
    else
    begin
      UPD_O <= commit;
      UPD_ID_O <= commit ? rx_id_q : UPD_ID_O;
      RX_ERR_O <= (rx_state_q == R_IDLE && RX_START_I && !len_ok(RX_ID_I, RX_LEN_I))
                  || ((rx_state_q == R_TAKE) && rx_take && RX_LAST_I && !rx_fit);
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      rtcm_valid_q <= 1'b0;
      rtcm_data_q <= 8'h00;
    end
    else if ((rx_state_q == R_TAKE) && rx_take && (rx_id_q == ID_RTCM))
    begin
      rtcm_valid_q <= 1'b1;
      rtcm_data_q <= RX_DATA_I;
    end
    else if (RTCM_READY_I)
    begin
      rtcm_valid_q <= 1'b0;
    end
  end
  assign RTCM_VALID_O = rtcm_valid_q;
  assign RTCM_DATA_O = rtcm_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Running time

  logic [4:0] tick_q;
  logic [19:0] run_us_q;
  logic [31:0] run_sec_q;

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      tick_q <= 5'h00;
      run_us_q <= 20'h00000;
      run_sec_q <= 32'h00000000;
    end
    else if (tick_q == US_LAST)
    begin
      tick_q <= 5'h00;
      run_us_q <= (run_us_q == USEC_LAST) ? 20'h00000 : 20'(run_us_q + 20'h00001);
      run_sec_q <= (run_us_q == USEC_LAST) ? 32'(run_sec_q + 32'h00000001) : run_sec_q;
    end
    else
    begin
      tick_q <= 5'(tick_q + 5'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path

  tx_state_t tx_state_q;
  logic [7:0] tx_id_q;
  logic [7:0] tx_idx_q;
  logic [1:0] tx_slot_q;
  logic tx_bank_q;
  logic [95:0] snap_q;
  logic [7:0] tx_rlen;
  logic tx_end;

  assign tx_rlen = rd_len(TX_ID_I, long_q[act_q[SLOT_BODY_VEL]]);
  assign tx_end = (tx_idx_q == 8'(TX_LEN_O - 8'h01));
  assign st.raddr_a = {tx_bank_q, tx_slot_q, tx_idx_q[IDX_W-1:0]};
  assign TX_VALID_O = (tx_state_q == T_SEND);
  assign TX_LAST_O = (tx_state_q == T_SEND) && tx_end;

  // Request capture and byte sequencing
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      tx_state_q <= T_IDLE;
      tx_idx_q <= 8'h00;
    end
    else
    begin
      case (tx_state_q)
        T_IDLE:
          if (TX_REQ_I && tx_rlen != LEN_NONE)
          begin
            tx_state_q <= T_ADDR;
            tx_idx_q <= 8'h00;
          end
        T_ADDR: tx_state_q <= T_LOAD;
        T_LOAD: tx_state_q <= T_SEND;
        T_SEND:
          if (TX_READY_I)
          begin
            tx_state_q <= tx_end ? T_IDLE : T_ADDR;
            tx_idx_q <= tx_end ? tx_idx_q : 8'(tx_idx_q + 8'h01);
          end
        default: tx_state_q <= T_IDLE;
      endcase
    end
  end

  // Snapshot so that a payload stays coherent while it streams
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      tx_id_q <= 8'h00;
      tx_slot_q <= SLOT_NONE;
      tx_bank_q <= 1'b0;
      snap_q <= 96'h0;
      TX_LEN_O <= 8'h00;
      TX_START_O <= 1'b0;
      TX_ERR_O <= 1'b0;
    end
    else
    begin
      TX_START_O <= (tx_state_q == T_IDLE) && TX_REQ_I && (tx_rlen != LEN_NONE);
      // correction packet cannot be read back
      TX_ERR_O <= (tx_state_q == T_IDLE) && TX_REQ_I && (tx_rlen == LEN_NONE);
      if (tx_state_q == T_IDLE && TX_REQ_I)
      begin
        tx_id_q <= TX_ID_I;
        tx_slot_q <= slot_of(TX_ID_I);
        tx_bank_q <= act_q[slot_of(TX_ID_I) == SLOT_NONE ? SLOT_EXT_VEL : slot_of(TX_ID_I)];
        TX_LEN_O <= tx_rlen;
        case (TX_ID_I)
          ID_RUN_TIME: snap_q <= {32'h0, 12'h000, run_us_q, run_sec_q};
          ID_MAG_FIELD: snap_q <= {MAG_Z_I, MAG_Y_I, MAG_X_I};
          ID_EXT_TIME: snap_q <= {32'h0, UNIX_USEC_I, UNIX_SEC_I};
          ID_GEOID: snap_q <= {64'h0, GEOID_I};
          default: snap_q <= 96'h0;
        endcase
      end
    end
  end

  // byte of the current field, least significant first
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      TX_DATA_O <= 8'h00;
    end
    else if (tx_state_q == T_LOAD)
    begin
      TX_DATA_O <= (tx_slot_q != SLOT_NONE) ? st.rdata_a : snap_q[8 * tx_idx_q[3:0] +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_bad_len_drop: assert property (
    (rx_state_q == R_IDLE && RX_START_I && !len_ok(RX_ID_I, RX_LEN_I) && RX_LEN_I != LEN_NONE)
    |=> (rx_state_q == R_DROP) ##0 $stable(act_q))
    else $error("bad length not dropped");
  a_zero_len_idle: assert property (
    (rx_state_q == R_IDLE && RX_START_I && RX_LEN_I == LEN_NONE)
    |=> (rx_state_q == R_IDLE) ##0 RX_ERR_O ##0 $stable(act_q))
    else $error("zero length not refused");
  a_ext_vel_swap: assert property (
    (commit && rx_id_q == ID_EXT_VEL) |=> (act_q[0] != $past(act_q[0])))
    else $error("ext velocity bank not swapped");
  a_body_short_ok: assert property (
    (rx_state_q == R_IDLE && RX_START_I && RX_ID_I == ID_BODY_VEL && RX_LEN_I == LEN_BODY_SHORT)
    |=> rx_state_q == R_TAKE)
    else $error("short body velocity refused");
  a_body_form: assert property (
    (commit && rx_id_q == ID_BODY_VEL) |=> (NAV_BODY_LONG_O == ($past(rx_len_q) == LEN_BODY_LONG)))
    else $error("body velocity form wrong");
  a_heading_len: assert property (
    (tx_state_q == T_IDLE && TX_REQ_I && TX_ID_I == ID_EXT_HDG) |=> TX_START_O && TX_LEN_O == 8'h08)
    else $error("heading length wrong");
  a_run_sec_wrap: assert property (
    (tick_q == US_LAST && run_us_q == USEC_LAST) |=> run_us_q == 20'h0 ##0
    run_sec_q == 32'($past(run_sec_q) + 32'h1))
    else $error("running time wrap wrong");
  a_mag_len: assert property (
    (tx_state_q == T_IDLE && TX_REQ_I && TX_ID_I == ID_MAG_FIELD) |=> TX_LEN_O == 8'h0c)
    else $error("field length wrong");
  a_time_first: assert property (
    (tx_state_q == T_IDLE && TX_REQ_I && TX_ID_I == ID_EXT_TIME) |-> ##3 TX_VALID_O
    && TX_DATA_O == $past(UNIX_SEC_I[7:0], 3))
    else $error("time low byte not first");
  a_geoid_len: assert property (
    (tx_state_q == T_IDLE && TX_REQ_I && TX_ID_I == ID_GEOID) |=> TX_LEN_O == 8'h04)
    else $error("geoid length wrong");
  a_rtcm_pass: assert property (
    (rx_state_q == R_TAKE && rx_take && rx_id_q == ID_RTCM)
    |=> RTCM_VALID_O && RTCM_DATA_O == $past(RX_DATA_I))
    else $error("correction byte altered");
  a_le_order: assert property (
    (tx_state_q == T_LOAD && tx_slot_q == SLOT_NONE) |=> TX_DATA_O == $past(snap_q[8 * tx_idx_q[3:0] +: 8]))
    else $error("byte order wrong");

  c_body_short: cover property (commit && rx_id_q == ID_BODY_VEL && rx_len_q == LEN_BODY_SHORT);
  c_body_long: cover property (commit && rx_id_q == ID_BODY_VEL && rx_len_q == LEN_BODY_LONG);
  c_rtcm_stall: cover property (RTCM_VALID_O && !RTCM_READY_I && RX_VALID_I && !RX_READY_O);
  c_run_time_tx: cover property (TX_LAST_O && TX_READY_I && tx_id_q == ID_RUN_TIME);
endmodule : aux_sensor_packet_codec

/* File: codec_pkg.sv */
// Purpose: Shared constants and types for the auxiliary sensor packet codec
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Payload bytes are little-endian, fields packed with no padding
package codec_pkg;
  // Packet identifiers
  localparam logic [7:0] ID_EXT_VEL = 8'h2e;
  localparam logic [7:0] ID_BODY_VEL = 8'h2f;
  localparam logic [7:0] ID_EXT_HDG = 8'h30;
  localparam logic [7:0] ID_RUN_TIME = 8'h31;
  localparam logic [7:0] ID_MAG_FIELD = 8'h32;
  localparam logic [7:0] ID_EXT_TIME = 8'h34;
  localparam logic [7:0] ID_GEOID = 8'h36;
  localparam logic [7:0] ID_RTCM = 8'h37;
  // Payload lengths in bytes
  localparam logic [7:0] LEN_EXT_VEL = 8'h18;
  localparam logic [7:0] LEN_BODY_SHORT = 8'h10;
  localparam logic [7:0] LEN_BODY_LONG = 8'h18;
  localparam logic [7:0] LEN_EXT_HDG = 8'h08;
  localparam logic [7:0] LEN_RUN_TIME = 8'h08;
  localparam logic [7:0] LEN_MAG_FIELD = 8'h0c;
  localparam logic [7:0] LEN_EXT_TIME = 8'h08;
  localparam logic [7:0] LEN_GEOID = 8'h04;
  localparam logic [7:0] LEN_RTCM_MIN = 8'h01;
  localparam logic [7:0] LEN_RTCM_MAX = 8'hff;
  localparam logic [7:0] LEN_NONE = 8'h00;
  // Store layout: {bank, slot, byte index}
  localparam int STORE_AW = 8;
  localparam int IDX_W = 5;
  localparam logic [1:0] SLOT_EXT_VEL = 2'h0;
  localparam logic [1:0] SLOT_BODY_VEL = 2'h1;
  localparam logic [1:0] SLOT_EXT_HDG = 2'h2;
  localparam logic [1:0] SLOT_NONE = 2'h3;
  // Running time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);
  localparam logic [19:0] USEC_LAST = 20'hf423f;
  // State machines
  typedef enum logic [1:0] {R_IDLE, R_TAKE, R_DROP} rx_state_t;
  typedef enum logic [1:0] {T_IDLE, T_ADDR, T_LOAD, T_SEND} tx_state_t;
endpackage : codec_pkg

/* File: store_if.sv */
// Purpose: Connects the codec core to its payload byte store
// Assumes: One write port and two registered read ports
// Notes:   Addresses are {bank, slot, byte index}
`timescale 1ns/1ps
interface store_if;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr_a;
  logic [7:0] rdata_a;
  logic [7:0] raddr_b;
  logic [7:0] rdata_b;
  modport owner (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : store_if

/* File: pay_store.sv */
// Purpose: Byte store holding two banks of each of the packet 46, 47 and 48 payloads
// Assumes: Same clock as the codec core
// Notes:   Read data come out of a register one cycle after the address
`timescale 1ns/1ps
module pay_store
  import codec_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Store port
  store_if.mem st
);
  logic [7:0] mem_q [0:(1 << STORE_AW) - 1];

  // Byte write
  always_ff @(posedge clk_i)
  begin
    if (st.we)
    begin
      mem_q[st.waddr] <= st.wdata;
    end
  end

  // Registered reads
  always_ff @(posedge clk_i)
  begin
    st.rdata_a <= mem_q[st.raddr_a];
    st.rdata_b <= mem_q[st.raddr_b];
  end
endmodule : pay_store

/* File: host_model.sv */
// Purpose: Host side that writes payloads into the codec and reads them back
// Assumes: Everything driven 1 ns after the clock rises
// Notes: An idle data line shows the inverse of its last byte
`timescale 1ns/1ps
module host_model
(
  // Clock and stall coin
  input wire logic clk_i,
  input wire logic coin_i,
  // Payload stream into the codec
  output logic rx_start_o,
  output logic [7:0] rx_id_o,
  output logic [7:0] rx_len_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  input wire logic rx_ready_i,
  // Read requests and returned bytes
  output logic tx_req_o,
  output logic [7:0] tx_id_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] got_q[$];
  logic coin_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial
  begin
    {rx_start_o, rx_valid_o, rx_last_o, tx_req_o, tx_ready_o} = 5'h00;
    {rx_id_o, rx_len_o, rx_data_o, tx_id_o} = 32'h0;
  end
  // Sink keeps accepted bytes and stalls at random
  always @(posedge clk_i)
  begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
      got_q.push_back(tx_data_i);
    coin_q = coin_i;
    #1;
    tx_ready_o = coin_q;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // header length given
  // Header strobe, then each byte held until taken
  task automatic send(input logic [7:0] id, input logic [7:0] len, input logic [7:0] b[$]);
    logic r;
    @(posedge clk_i);
    #1;
    {rx_start_o, rx_id_o, rx_len_o} = {1'b1, id, len};
    @(posedge clk_i);
    #1;
    rx_start_o = 1'b0;
    foreach (b[k])
    begin
      {rx_valid_o, rx_data_o, rx_last_o} = {1'b1, b[k], k == b.size() - 1};
      r = 1'b0;
      for (int w = 0; w < 200 && !r; w++)
      begin
        @(negedge clk_i);
        r = rx_ready_i;
        @(posedge clk_i);
        #1;
      end
    end
    {rx_valid_o, rx_last_o} = 2'b00;
    rx_data_o = ~rx_data_o;
  endtask : send
  // One-cycle read request
  task automatic request(input logic [7:0] id);
    got_q.delete();
    @(posedge clk_i);
    #1;
    {tx_req_o, tx_id_o} = {1'b1, id};
    @(posedge clk_i);
    #1;
    tx_req_o = 1'b0;
  endtask : request
endmodule : host_model

/* File: aux_sensor_packet_codec_tb.sv */
// Purpose: Self-checking bench for the auxiliary sensor packet codec
// Assumes: Host model on the packet side, bench plays the navigation core
// Notes: Random payloads from a fixed seed, plus bad-length corner cases
`timescale 1ns/1ps
module aux_sensor_packet_codec_tb;
  import codec_pkg::*;
  typedef logic [7:0] bq_t[$];
  logic clk, srst, coin, rtcm_rdy, rx_start, rx_valid, rx_last, rx_ready;
  logic rx_err, upd, body_long, rtcm_valid, tx_req, tx_start, tx_err;
  logic tx_valid, tx_last, tx_ready;
  logic [7:0] rx_id, rx_len, rx_data, upd_id, nav_data, rtcm_data, tx_id, tx_len, tx_data;
  logic [1:0] nav_slot;
  logic [4:0] nav_idx;
  logic [31:0] live[6];
  logic [31:0] usec;
  bq_t pay, keep46, keep47, rtcm_q;
  int seed = 32'h98153ada;
  int fails = 0;
  int n_tests = 0;
  int n_upd = 0;
  int n_err = 0;
  int n_last = 0;
  logic [7:0] bad[4][3] = '{'{8'h2f, 8'd20, 8'd20}, '{8'h2e, 8'd24, 8'd23},
    '{8'h30, 8'd9, 8'd9}, '{8'h31, 8'd8, 8'd8}};
  logic [7:0] noread[4] = '{8'h33, 8'h35, 8'h37, 8'hff};
  ////////////////////////////////////////////////////////////////////////////////
  aux_sensor_packet_codec aux_sensor_packet_codec_inst (.REF_CLK_I(clk), .SRST_I(srst),
    .RX_START_I(rx_start), .RX_ID_I(rx_id), .RX_LEN_I(rx_len), .RX_VALID_I(rx_valid),
    .RX_DATA_I(rx_data), .RX_LAST_I(rx_last), .RX_READY_O(rx_ready), .RX_ERR_O(rx_err),
    .UPD_O(upd), .UPD_ID_O(upd_id), .NAV_SLOT_I(nav_slot), .NAV_IDX_I(nav_idx),
    .NAV_DATA_O(nav_data), .NAV_BODY_LONG_O(body_long), .MAG_X_I(live[0]),
    .MAG_Y_I(live[1]), .MAG_Z_I(live[2]), .UNIX_SEC_I(live[3]), .UNIX_USEC_I(live[4]),
    .GEOID_I(live[5]), .RTCM_VALID_O(rtcm_valid), .RTCM_DATA_O(rtcm_data),
    .RTCM_READY_I(rtcm_rdy), .TX_REQ_I(tx_req), .TX_ID_I(tx_id), .TX_START_O(tx_start),
    .TX_LEN_O(tx_len), .TX_ERR_O(tx_err), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
    .TX_LAST_O(tx_last), .TX_READY_I(tx_ready));
  host_model host_model_inst (.clk_i(clk), .coin_i(coin), .rx_start_o(rx_start),
    .rx_id_o(rx_id), .rx_len_o(rx_len), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .rx_last_o(rx_last), .rx_ready_i(rx_ready), .tx_req_o(tx_req), .tx_id_o(tx_id),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Random stalls of both sinks
  always @(posedge clk)
  begin
    #1;
    rtcm_rdy = 1'($random(seed));
    coin = 1'($random(seed));
  end
  // Count result pulses and collect forwarded corrections
  always @(posedge clk)
  begin
    if (upd === 1'b1)
      n_upd++;
    if (rx_err === 1'b1)
      n_err++;
    if (tx_valid === 1'b1 && tx_last === 1'b1 && tx_ready === 1'b1)
      n_last++;
    if (rtcm_valid === 1'b1 && rtcm_rdy === 1'b1)
      rtcm_q.push_back(rtcm_data);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // A used-up wait counts as a mismatch
  task automatic bound(input int w);
    if (w >= 3000)
    begin
      fails++;
      $display("[FAIL] %0t wait ran out", $time);
      final_report();
    end
  endtask : bound
  // Random payload of n bytes
  task automatic fill(input int n);
    pay.delete();
    repeat (n) pay.push_back(8'($random(seed)));
  endtask : fill
  // Little-endian bytes of a list of words
  function automatic bq_t le(input logic [31:0] w[$]);
    bq_t q;
    foreach (w[i])
      for (int b = 0; b < 4; b++)
        q.push_back(w[i][8*b +: 8]);
    return q;
  endfunction : le
  // Write a packet and count the result pulses
  task automatic put(input logic [7:0] id, input int len, input int ups, input int errs);
    int u;
    int e;
    u = n_upd;
    e = n_err;
    host_model_inst.send(id, 8'(len), pay);
    repeat (3) @(posedge clk);
    #1;
    check(32'(n_upd - u), 32'(ups), "commit count");
    check(32'(n_err - e), 32'(errs), "drop count");
  endtask : put
  // Wait for n returned bytes
  task automatic wait_bytes(input int n);
    int w;
    for (w = 0; w < 3000 && host_model_inst.got_q.size() < n; w++)
      @(posedge clk);
    bound(w);
    @(posedge clk);
    #1;
  endtask : wait_bytes
  // Read a packet back and compare every byte
  task automatic get(input logic [7:0] id, input bq_t exp);
    int l;
    l = n_last;
    host_model_inst.request(id);
    check(tx_start, 1'b1, "start");
    check(tx_len, 8'(exp.size()), "length");
    wait_bytes(exp.size());
    check(32'(n_last - l), 32'h1, "last marker");
    foreach (exp[k])
      check(host_model_inst.got_q[k], exp[k], "byte");
  endtask : get
  // Byte of the active bank seen by the navigation core
  task automatic nav(input logic [1:0] slot, input int idx, input logic [7:0] exp);
    nav_slot = slot;
    nav_idx = 5'(idx);
    repeat (2) @(posedge clk);
    #1;
    check(nav_data, exp, "nav byte");
  endtask : nav
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int w;
    {srst, coin, rtcm_rdy, nav_slot, nav_idx} = 10'h200;
    foreach (live[i])
      live[i] = 32'h0;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    check({upd_id, body_long, tx_valid, rtcm_valid}, 11'h000, "reset");
    fill(8);
    put(ID_EXT_HDG, 8, 1, 0);
    check(upd_id, ID_EXT_HDG, "update id");
    for (int k = 0; k < 8; k++)
      nav(SLOT_EXT_HDG, k, pay[k]);
    get(ID_EXT_HDG, pay);
    $display("test heading done");
    fill(24);
    keep46 = pay;
    put(ID_EXT_VEL, 24, 1, 0);
    nav(SLOT_EXT_VEL, 23, pay[23]);
    get(ID_EXT_VEL, pay);
    fill(16);
    put(ID_BODY_VEL, 16, 1, 0);
    check(body_long, 1'b0, "short form");
    nav(SLOT_BODY_VEL, 12, pay[12]);
    get(ID_BODY_VEL, pay);
    fill(24);
    keep47 = pay;
    put(ID_BODY_VEL, 24, 1, 0);
    check(body_long, 1'b1, "long form");
    nav(SLOT_BODY_VEL, 20, pay[20]);
    get(ID_BODY_VEL, pay);
    $display("test velocity done");
    foreach (bad[i])
    begin
      fill(bad[i][2]);
      put(bad[i][0], bad[i][1], 0, 1);
    end
    check(body_long, 1'b1, "form kept");
    get(ID_EXT_VEL, keep46);
    get(ID_BODY_VEL, keep47);
    $display("test bad length done");
    foreach (live[i])
      live[i] = $random(seed);
    get(ID_MAG_FIELD, le('{live[0], live[1], live[2]}));
    get(ID_EXT_TIME, le('{live[3], live[4]}));
    get(ID_GEOID, le('{live[5]}));
    // consumer rebuilds the geoid word for sea-level height
    check({host_model_inst.got_q[3], host_model_inst.got_q[2], host_model_inst.got_q[1],
      host_model_inst.got_q[0]}, live[5], "geoid word");
    host_model_inst.request(ID_RUN_TIME);
    check(tx_len, LEN_RUN_TIME, "run length");
    wait_bytes(8);
    for (int k = 0; k < 4; k++)
      check(host_model_inst.got_q[k], 8'h00, "run seconds");
    usec = le('{32'h0}).size() == 4 ? {host_model_inst.got_q[7], host_model_inst.got_q[6],
      host_model_inst.got_q[5], host_model_inst.got_q[4]} : 32'h0;
    check(usec != 0 && usec < 32'd1000000, 1'b1, "run usec");
    foreach (noread[i])
    begin
      host_model_inst.request(noread[i]);
      check({tx_err, tx_start}, 2'b10, "refused id");
    end
    $display("test read done");
    for (int n = 0; n < 4; n++)
    begin
      rtcm_q.delete();
      fill(n == 0 ? 1 : n == 1 ? 255 : n == 2 ? 0 : 37);
      put(ID_RTCM, pay.size(), n == 2 ? 0 : 1, n == 2 ? 1 : 0);
      for (w = 0; w < 3000 && rtcm_q.size() < pay.size(); w++)
        @(posedge clk);
      bound(w);
      check(rtcm_q.size(), pay.size(), "rtcm count");
      foreach (pay[k])
        check(rtcm_q[k], pay[k], "rtcm byte");
    end
    $display("test corrections done");
    final_report();
  end
endmodule : aux_sensor_packet_codec_tb
